// file: design/aur_pkg.sv
// Package: constants and types of the asynchronous serial receiver
package aur_pkg;

    // Clock and default bit rate
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned BAUD_DEF = 9600;
    localparam int unsigned TICKS_PER_BIT = 16;
    localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / (TICKS_PER_BIT * BAUD_DEF) - 1);

    // Tick counts within one bit, and the last data bit count for eight- and nine-bit frames
    localparam logic [3:0] HALF_CNT = 4'h7;
    localparam logic [3:0] VOTE_A_CNT = 4'hd;
    localparam logic [3:0] VOTE_B_CNT = 4'he;
    localparam logic [3:0] CENTER_CNT = 4'hf;
    localparam logic [3:0] LAST_BIT8 = 4'h7;
    localparam logic [3:0] LAST_BIT9 = 4'h8;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BAUD = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

    // Field positions
    localparam int STAT_PEND_BIT = 0;
    localparam int STAT_OVR_BIT = 1;
    localparam int STAT_FERR_BIT = 2;
    localparam int STAT_BUSY_BIT = 3;
    localparam int STAT_CNT_LSB = 4;
    localparam int IRQ_CHAR_BIT = 0;
    localparam int IRQ_FERR_BIT = 1;
    localparam int IRQ_OVR_BIT = 2;
    localparam int DATA_FERR_BIT = 9;

    // Reset values
    localparam logic [6:0] CTRL_RST = 7'h00;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;
    localparam logic [2:0] SYNC_RST = 3'h7;

    // Control register layout, top bit (bit 6) listed first, bit 0 last
    typedef struct packed {
        logic global_interrupt_enable;
        logic peripheral_interrupt_enable;
        logic receive_interrupt_enable;
        logic nine_bit;
        logic clocked_mode;
        logic serial_port_enable;
        logic continuous_receive_enable;
    } aur_ctrl_t;

    // One received character with its framing result
    typedef struct packed {
        logic ferr;
        logic [8:0] data;
    } aur_char_t;

    typedef enum logic [2:0] {
        SEL_CTRL,
        SEL_BAUD,
        SEL_DATA,
        SEL_STAT,
        SEL_IRQ_STAT,
        SEL_IRQ_MASK,
        SEL_NONE
    } aur_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_STOP
    } aur_rx_state_t;

endpackage

// file: design/aur_rx_fifo.sv
// Two-entry receive FIFO held in flip-flops
`timescale 1ns/1ns
module aur_rx_fifo
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Control
    input wire logic flush_i,
    input wire logic push_i,
    input wire aur_pkg::aur_char_t push_char_i,
    input wire logic pop_i,
    // State
    output aur_pkg::aur_char_t head_o,
    output logic [1:0] count_o,
    output logic full_o
);
    aur_pkg::aur_char_t mem_reg [2];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] cnt_reg;
    logic do_push;
    logic do_pop;

    assign do_push = push_i && (cnt_reg != 2'h2);
    assign do_pop = pop_i && (cnt_reg != 2'h0);
    assign head_o = mem_reg[rd_ptr_reg];
    assign count_o = cnt_reg;
    assign full_o = (cnt_reg == 2'h2);

    always_ff @(posedge sys_clk_i)
    begin
        if (do_push)
        begin
            mem_reg[wr_ptr_reg] <= push_char_i;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i || flush_i)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (do_pop)
            begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            cnt_reg <= 2'(cnt_reg + {1'b0, do_push} - {1'b0, do_pop});
        end
    end

endmodule // aur_rx_fifo

// file: design/aur_receiver.sv
// Asynchronous serial receiver with APB registers and interrupt
`timescale 1ns/1ns
module aur_receiver
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // APB slave
    input wire logic [7:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    // Serial line and interrupt
    input wire logic rx_line_i,
    output logic irq_o
);
    function automatic aur_pkg::aur_sel_t reg_sel(input logic [7:0] addr);
        unique case (addr)
            aur_pkg::OFS_CTRL: reg_sel = aur_pkg::SEL_CTRL;
            aur_pkg::OFS_BAUD: reg_sel = aur_pkg::SEL_BAUD;
            aur_pkg::OFS_DATA: reg_sel = aur_pkg::SEL_DATA;
            aur_pkg::OFS_STAT: reg_sel = aur_pkg::SEL_STAT;
            aur_pkg::OFS_IRQ_STAT: reg_sel = aur_pkg::SEL_IRQ_STAT;
            aur_pkg::OFS_IRQ_MASK: reg_sel = aur_pkg::SEL_IRQ_MASK;
            default: reg_sel = aur_pkg::SEL_NONE;
        endcase
    endfunction

    function automatic logic maj3(input logic a, input logic b, input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction

    aur_pkg::aur_ctrl_t ctrl_reg;
    aur_pkg::aur_rx_state_t state_reg;
    aur_pkg::aur_sel_t sel;
    aur_pkg::aur_char_t push_char, head;
    logic [31:0] prdata_reg, rd_mux;
    logic [15:0] baud_div_reg, div_cnt_reg;
    logic [8:0] shift_reg;
    logic [3:0] tick_cnt_reg, bit_cnt_reg, last_bit;
    logic [2:0] irq_stat_reg, irq_mask_reg, sync_reg, irq_event;
    logic [1:0] vote_reg, fifo_cnt;
    logic ovr_reg, pready_reg, pslverr_reg, pop_ok_reg, irq_reg;
    logic line_reg, line_prev_reg, tick_reg;
    logic rx_on, fall, maj_bit, shift_en, stop_done, acc;
    logic wr_fire, rd_fire, pop, pend, fifo_full;

    // Software must also set the pin as input and clear its analog select
    assign rx_on = ctrl_reg.continuous_receive_enable && ctrl_reg.serial_port_enable
        && !ctrl_reg.clocked_mode;
    assign fall = line_prev_reg && !line_reg;
    assign maj_bit = maj3(vote_reg[1], vote_reg[0], line_reg);
    assign shift_en = tick_reg && (state_reg == aur_pkg::ST_DATA)
        && (tick_cnt_reg == aur_pkg::CENTER_CNT);
    assign stop_done = tick_reg && (state_reg == aur_pkg::ST_STOP)
        && (tick_cnt_reg == aur_pkg::CENTER_CNT);
    assign last_bit = ctrl_reg.nine_bit ? aur_pkg::LAST_BIT9 : aur_pkg::LAST_BIT8;
    assign push_char.ferr = !maj_bit;
    assign push_char.data = ctrl_reg.nine_bit ? shift_reg : {1'b0, shift_reg[8:1]};
    assign pend = rx_on && (fifo_cnt != 2'h0);
    assign irq_event = {stop_done && fifo_full, stop_done && !maj_bit, stop_done};

    assign acc = psel_i && penable_i;
    assign sel = reg_sel(paddr_i);
    assign wr_fire = acc && pready_reg && pwrite_i;
    assign rd_fire = acc && pready_reg && !pwrite_i;
    assign pop = rd_fire && (sel == aur_pkg::SEL_DATA) && pop_ok_reg;

    assign pready_o = pready_reg;
    assign prdata_o = prdata_reg;
    assign pslverr_o = pslverr_reg;
    assign irq_o = irq_reg;

    aur_rx_fifo u_fifo
    (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .flush_i(!rx_on),
        .push_i(stop_done && !fifo_full),
        .push_char_i(push_char),
        .pop_i(pop),
        .head_o(head),
        .count_o(fifo_cnt),
        .full_o(fifo_full)
    );

    // Three-stage pin synchroniser; second and third must agree
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            sync_reg <= aur_pkg::SYNC_RST;
            line_reg <= 1'b1;
            line_prev_reg <= 1'b1;
        end
        else
        begin
            sync_reg <= {sync_reg[1:0], rx_line_i};
            if (sync_reg[1] == sync_reg[2])
                line_reg <= sync_reg[2];
            line_prev_reg <= line_reg;
        end
    end

    // Sixteen-per-bit tick
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i || !rx_on || div_cnt_reg == baud_div_reg)
            div_cnt_reg <= 16'h0000;
        else
            div_cnt_reg <= 16'(div_cnt_reg + 16'h0001);
        tick_reg <= !srst_i && rx_on && (div_cnt_reg == baud_div_reg);
    end

    // Bit recovery sequence; tick count restarts at every bit centre
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i || !rx_on)
        begin
            state_reg <= aur_pkg::ST_IDLE;
            tick_cnt_reg <= 4'h0;
            bit_cnt_reg <= 4'h0;
        end
        else
        begin
            if (state_reg == aur_pkg::ST_IDLE)
                tick_cnt_reg <= 4'h0;
            else if (tick_reg)
                tick_cnt_reg <= 4'(tick_cnt_reg + 4'h1);
            unique case (state_reg)
                aur_pkg::ST_IDLE:
                    if (fall && !ovr_reg)
                        state_reg <= aur_pkg::ST_START;
                aur_pkg::ST_START:
                    if (tick_reg && tick_cnt_reg == aur_pkg::HALF_CNT)
                    begin
                        // Glitch on an idle line is dropped without an error
                        tick_cnt_reg <= 4'h0;
                        bit_cnt_reg <= 4'h0;
                        state_reg <= line_reg ? aur_pkg::ST_IDLE : aur_pkg::ST_DATA;
                    end
                aur_pkg::ST_DATA:
                    if (shift_en)
                    begin
                        bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
                        if (bit_cnt_reg == last_bit)
                            state_reg <= aur_pkg::ST_STOP;
                    end
                aur_pkg::ST_STOP:
                    if (stop_done)
                        state_reg <= aur_pkg::ST_IDLE;
            endcase
        end
    end

    // Majority samples just ahead of the bit centre
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
            vote_reg <= 2'h3;
        else if (tick_reg && tick_cnt_reg == aur_pkg::VOTE_A_CNT)
            vote_reg[1] <= line_reg;
        else if (tick_reg && tick_cnt_reg == aur_pkg::VOTE_B_CNT)
            vote_reg[0] <= line_reg;
    end

    // Receive shift register, bits enter at the top; first bit ends in bit 0 for nine-bit frames, bit 1 for eight-bit
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
            shift_reg <= 9'h000;
        else if (shift_en)
            shift_reg <= {maj_bit, shift_reg[8:1]};
    end

    // Sticky overrun; only dropping the receive enable clears it
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i || !ctrl_reg.continuous_receive_enable)
            ovr_reg <= 1'b0;
        else if (stop_done && fifo_full)
            ovr_reg <= 1'b1;
    end

    // Software-written configuration
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            ctrl_reg <= aur_pkg::aur_ctrl_t'(aur_pkg::CTRL_RST);
            baud_div_reg <= aur_pkg::BAUD_DIV_RST;
            irq_mask_reg <= aur_pkg::IRQ_MASK_RST;
        end
        else if (wr_fire)
        begin
            unique case (sel)
                aur_pkg::SEL_CTRL: ctrl_reg <= aur_pkg::aur_ctrl_t'(pwdata_i[6:0]);
                aur_pkg::SEL_BAUD: baud_div_reg <= pwdata_i[15:0];
                aur_pkg::SEL_IRQ_MASK: irq_mask_reg <= pwdata_i[2:0];
                default: ;
            endcase
        end
    end

    // Event status, write one to clear; a new event beats the clear
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
            irq_stat_reg <= 3'h0;
        else if (wr_fire && sel == aur_pkg::SEL_IRQ_STAT)
            irq_stat_reg <= (irq_stat_reg & ~pwdata_i[2:0]) | irq_event;
        else
            irq_stat_reg <= irq_stat_reg | irq_event;
    end

    // Receive request needs all three enables; event bits share the global gates
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
            irq_reg <= 1'b0;
        else
            irq_reg <= ctrl_reg.global_interrupt_enable
                && ctrl_reg.peripheral_interrupt_enable
                && ((ctrl_reg.receive_interrupt_enable && pend)
                || (|(irq_stat_reg & irq_mask_reg)));
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (sel)
            aur_pkg::SEL_CTRL: rd_mux[6:0] = ctrl_reg;
            aur_pkg::SEL_BAUD: rd_mux[15:0] = baud_div_reg;
            aur_pkg::SEL_DATA:
            begin
                if (fifo_cnt != 2'h0)
                begin
                    rd_mux[aur_pkg::DATA_FERR_BIT:0] = head;
                end
            end
            aur_pkg::SEL_STAT:
            begin
                rd_mux[aur_pkg::STAT_PEND_BIT] = pend;
                rd_mux[aur_pkg::STAT_OVR_BIT] = ovr_reg;
                rd_mux[aur_pkg::STAT_FERR_BIT] = (fifo_cnt != 2'h0) && head.ferr;
                rd_mux[aur_pkg::STAT_BUSY_BIT] = (state_reg != aur_pkg::ST_IDLE);
                rd_mux[aur_pkg::STAT_CNT_LSB +: 2] = fifo_cnt;
            end
            aur_pkg::SEL_IRQ_STAT: rd_mux[2:0] = irq_stat_reg;
            aur_pkg::SEL_IRQ_MASK: rd_mux[2:0] = irq_mask_reg;
            default: ;
        endcase
    end

    // One wait state: read data is captured on the same edge that raises pready
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            pop_ok_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= acc && !pready_reg;
            if (acc && !pready_reg)
            begin
                prdata_reg <= pwrite_i ? 32'h0000_0000 : rd_mux;
                pslverr_reg <= (sel == aur_pkg::SEL_NONE);
                pop_ok_reg <= (fifo_cnt != 2'h0);
            end
            else if (pready_reg)
                pslverr_reg <= 1'b0;
        end
    end

    default clocking ast_cb @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);

    AST_START_ON_FALL: assert property (
        $rose(state_reg == aur_pkg::ST_START) |-> $past(fall))
        else $error("start not caused by falling edge");
    AST_START_ABORT: assert property (
        (state_reg == aur_pkg::ST_START && tick_reg && tick_cnt_reg == aur_pkg::HALF_CNT
        && line_reg) |=> (state_reg == aur_pkg::ST_IDLE) && $stable(irq_stat_reg))
        else $error("high start centre not abandoned silently");
    AST_LSB_FIRST: assert property (
        shift_en |=> shift_reg[8] == $past(maj_bit) && shift_reg[7:0] == $past(shift_reg[8:1]))
        else $error("bit not shifted in at the top");
    AST_FERR_MARK: assert property (
        (stop_done && !fifo_full && fifo_cnt == 2'h0) |=> head.ferr == !$past(maj_bit))
        else $error("framing error not from stop sample");
    AST_PUSH_AFTER_STOP: assert property (
        (stop_done && !fifo_full && !pop) |=> fifo_cnt == $past(fifo_cnt) + 2'h1)
        else $error("character not queued after stop bit");
    AST_POP_ON_READ: assert property (
        (pop && !stop_done) |=> fifo_cnt == $past(fifo_cnt) - 2'h1)
        else $error("data read did not remove the oldest character");
    AST_DROP_OVERRUN: assert property (
        (stop_done && fifo_full && !pop) |=> ovr_reg && fifo_cnt == 2'h2)
        else $error("third character not discarded with overrun");
    AST_HOLD_OVERRUN: assert property (
        (ovr_reg && state_reg == aur_pkg::ST_IDLE) |=> state_reg == aur_pkg::ST_IDLE)
        else $error("reception started during overrun");
    AST_STAT_PEND: assert property (
        (acc && !pready_reg && !pwrite_i && sel == aur_pkg::SEL_STAT)
        |=> prdata_o[aur_pkg::STAT_PEND_BIT] == (rx_on && $past(fifo_cnt) != 2'h0))
        else $error("pending flag does not show FIFO contents");
    AST_IRQ_GATE: assert property (
        (irq_o && !$past(|(irq_stat_reg & irq_mask_reg))) |-> $past(pend
        && ctrl_reg.receive_interrupt_enable && ctrl_reg.peripheral_interrupt_enable
        && ctrl_reg.global_interrupt_enable))
        else $error("receive interrupt without all enables");

    COV_CHAR: cover property (stop_done && maj_bit && !fifo_full);
    COV_FERR: cover property (stop_done && !maj_bit);
    COV_OVERRUN: cover property (stop_done && fifo_full);
    COV_ABORT: cover property (state_reg == aur_pkg::ST_START ##1 state_reg == aur_pkg::ST_IDLE);

endmodule // aur_receiver

// file: test/aur_tx_model.sv
// Behavioural remote asynchronous transmitter driving the receive line
`timescale 1ns/1ns
module aur_tx_model
(
    // Clock
    input wire logic sys_clk_i,
    // Serial line
    output logic line_o
);
    // Drives the receive pin, which the block only ever reads
    initial line_o = 1'b1;

    // Entered at a rising edge; line idles high between frames
    task automatic send(input logic [8:0] data, input int nbits, input logic stop_bit,
        input int clks);
        line_o <= 1'b0;
        repeat (clks) @(posedge sys_clk_i);
        for (int i = 0; i < nbits; i++)
        begin
            line_o <= data[i];
            repeat (clks) @(posedge sys_clk_i);
        end
        line_o <= stop_bit;
        repeat (clks) @(posedge sys_clk_i);
        line_o <= 1'b1;
    endtask

    // Low pulse too short to be a start bit
    task automatic glitch(input int clks);
        line_o <= 1'b0;
        repeat (clks) @(posedge sys_clk_i);
        line_o <= 1'b1;
    endtask
endmodule // aur_tx_model

// file: test/aur_receiver_tb_top.sv
// Testbench of the asynchronous serial receiver with its APB registers
`timescale 1ns/1ns
module aur_receiver_tb_top;
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, irq, line;
    logic [31:0] prdata, rd;
    logic [8:0] ch [3];
    int err_count = 0;
    int checks = 0;
    int bclk = 16;

    always #10 sys_clk_i = ~sys_clk_i;

    aur_receiver u_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .paddr_i(paddr),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .rx_line_i(line),
        .irq_o(irq));
    aur_tx_model u_tx (.sys_clk_i(sys_clk_i), .line_o(line));

    task automatic summarize();
        if (err_count == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk_i);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            err_count++;
            summarize();
        end
        rd = prdata;
        chk("pslverr", {31'h0, pslverr}, {31'h0, a > 8'h14});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(name, rd, exp);
    endtask

    function automatic logic [31:0] stat(logic p, logic o, logic f, logic [1:0] c);
        return {26'h0, c, 1'b0, f, o, p};
    endfunction

    function automatic logic [31:0] dexp(logic [8:0] c, logic fe, logic nine);
        return {22'h0, fe, nine & c[8], c[7:0]};
    endfunction

    // Send one frame and let the push land
    task automatic tx(input logic [8:0] c, input int nb, input logic sb);
        u_tx.send(c, nb, sb, bclk);
        repeat (4) @(posedge sys_clk_i);
    endtask

    initial
    begin
        void'($urandom(80760));
        repeat (20) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        @(posedge sys_clk_i);
        rdchk("ctrl_rst", 8'h00, 32'h0);
        rdchk("baud_rst", 8'h04, 32'h144);
        rdchk("mask_rst", 8'h14, 32'h0);
        rdchk("unmapped", 8'h18, 32'h0);
        apb(8'h04, 1'b1, 32'h0);
        apb(8'h00, 1'b1, 32'h3);
        // Corner bytes first, then random; second half at a slower rate
        for (int i = 0; i < 4; i++)
        begin
            if (i == 2)
            begin
                apb(8'h04, 1'b1, 32'h1);
                bclk = 32;
            end
            ch[0] = (i == 0) ? 9'h000 : (i == 1) ? 9'h0ff : 9'($urandom_range(255));
            tx(ch[0], 8, 1'b1);
            rdchk("stat_one", 8'h0c, stat(1, 0, 0, 1));
            rdchk("data", 8'h08, dexp(ch[0], 1'b0, 1'b0));
            rdchk("stat_empty", 8'h0c, stat(0, 0, 0, 0));
        end
        ch[0] = 9'($urandom_range(255));
        tx(ch[0], 8, 1'b0);
        rdchk("ferr_stat", 8'h0c, stat(1, 0, 1, 1));
        rdchk("ferr_data", 8'h08, dexp(ch[0], 1'b1, 1'b0));
        rdchk("irq_stat", 8'h10, 32'h3);
        apb(8'h10, 1'b1, 32'h3);
        rdchk("irq_w1c", 8'h10, 32'h0);
        u_tx.glitch(bclk / 4);
        repeat (3 * bclk) @(posedge sys_clk_i);
        rdchk("glitch_stat", 8'h0c, stat(0, 0, 0, 0));
        rdchk("glitch_irq", 8'h10, 32'h0);
        // Three characters into the two-entry queue
        for (int k = 0; k < 3; k++)
        begin
            ch[k] = 9'($urandom_range(255));
            tx(ch[k], 8, 1'b1);
        end
        rdchk("ovr_stat", 8'h0c, stat(1, 1, 0, 2));
        rdchk("ovr_irq", 8'h10, 32'h5);
        tx(9'h0a5, 8, 1'b1);
        rdchk("ovr_hold", 8'h0c, stat(1, 1, 0, 2));
        rdchk("old0", 8'h08, dexp(ch[0], 1'b0, 1'b0));
        rdchk("old1", 8'h08, dexp(ch[1], 1'b0, 1'b0));
        tx(9'h05a, 8, 1'b1);
        rdchk("ovr_block", 8'h0c, stat(0, 1, 0, 0));
        apb(8'h00, 1'b1, 32'h0);
        apb(8'h00, 1'b1, 32'h3);
        apb(8'h10, 1'b1, 32'h7);
        rdchk("ovr_clear", 8'h0c, stat(0, 0, 0, 0));
        apb(8'h00, 1'b1, 32'hb);
        ch[0] = 9'($urandom_range(511));
        tx(ch[0], 9, 1'b1);
        rdchk("nine", 8'h08, dexp(ch[0], 1'b0, 1'b1));
        // Pending with only part of the interrupt enables
        apb(8'h00, 1'b1, 32'h1b);
        // Nine-bit mode is still on, so the frame carries nine data bits
        tx(9'h13c, 9, 1'b1);
        chk("irq_part", {31'h0, irq}, 32'h0);
        rdchk("pend_any", 8'h0c, stat(1, 0, 0, 1));
        apb(8'h00, 1'b1, 32'h7b);
        repeat (2) @(posedge sys_clk_i);
        chk("irq_all", {31'h0, irq}, 32'h1);
        apb(8'h0c, 1'b1, 32'h0);
        rdchk("pend_ro", 8'h0c, stat(1, 0, 0, 1));
        apb(8'h08, 1'b0, 32'h0);
        repeat (2) @(posedge sys_clk_i);
        chk("irq_pop", {31'h0, irq}, 32'h0);
        apb(8'h14, 1'b1, 32'h1);
        apb(8'h00, 1'b1, 32'h6b);
        repeat (2) @(posedge sys_clk_i);
        chk("irq_mask", {31'h0, irq}, 32'h1);
        apb(8'h10, 1'b1, 32'h1);
        repeat (2) @(posedge sys_clk_i);
        chk("irq_clr", {31'h0, irq}, 32'h0);
        apb(8'h00, 1'b1, 32'h3);
        tx(9'h081, 8, 1'b1);
        rdchk("pre_mode", 8'h0c, stat(1, 0, 0, 1));
        apb(8'h00, 1'b1, 32'h7);
        rdchk("clk_mode", 8'h0c, stat(0, 0, 0, 0));
        summarize();
    end
endmodule // aur_receiver_tb_top
